// file: core/ssl_core.sv
// Purpose: Serial line assist: software drive and read-back of an open-drain
//          clock line and data line, conditional edge detection, sampling and
//          clock stretching.
// Assumes: Pads are open drain; a low is driven by raising the output enable.
//          Port B logic runs on mclk_i; pad inputs are asynchronous.
// Notes:   Register reads return data in the cycle after the read strobe.
//          A flag's set beats its clear when both fall in one cycle.
//          Detection, sampling and stretching run only while enabled.
//          Pin levels lag the pads by the two synchroniser flops; port B's copy lags by one flop more.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module ssl_core
  import ssl_pkg::*;
#(
  parameter int AW = SSL_ADDR_BITS
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  // Register port
  input  wire logic [AW-1:0] reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [7:0]    reg_rdata_o,
  // Pads of port B bits four and five
  input  wire ssl_lines_t    pad_in_i,
  output ssl_lines_t         pad_out_o,
  output ssl_lines_t         pad_oe_o,
  // Port B own settings for the same two pins
  input  wire ssl_lines_t    portb_out_i,
  input  wire ssl_lines_t    portb_oe_i,
  // Synchronised pin levels, handed back to port B
  output ssl_lines_t         portb_in_o,
  // Interrupt requests toward the interrupt manager
  output logic               cond_one_irq_o,
  output logic               cond_two_irq_o
);

  // Refuse an address port too narrow for the register map
  if (AW < SSL_ADDR_BITS) begin : g_chk_aw
    $error("ssl_core address width too small for register map");
  end

  // Register state
  logic       data_out_q;
  logic       clock_out_q;
  logic       enable_q;
  logic       str_always_q;
  logic       str_cond_q;
  logic       stretch_q;
  logic       cond_one_q;
  logic       cond_two_q;
  logic       sample_q;
  logic       clk_rise_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Pin state
  ssl_lines_t line_s;
  ssl_lines_t line_prev_q;
  ssl_lines_t pad_out_q;
  ssl_lines_t pad_oe_q;
  logic       irq_one_q;
  logic       irq_two_q;

  // Decoded strobes
  logic [2:0] addr;
  logic       wr_data_line;
  logic       wr_clock_line;
  logic       wr_control;
  logic       wr_cond_one;
  logic       wr_cond_two;
  logic       wr_sample;
  logic       rd_sample;
  logic       addr_hi_zero;

  // Line events
  logic       clk_rise;
  logic       clk_fall;
  logic       dat_rise;
  logic       dat_fall;
  logic       cond_one_hit;
  logic       cond_two_hit;
  logic       stretch_set;
  logic       clk_pull_low;
  logic       dat_pull_low;

  // Pin synchroniser, idle lines read high
  ssl_sync #(
    .WIDTH  (2),
    .STAGES (SSL_SYNC_STAGES),
    .RST_V  (2'h3)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (pad_in_i),
    .sync_o  (line_s)
  );

  // Address decode; upper address bits must be zero
  assign addr = reg_addr_i[2:0];
  if (AW > SSL_ADDR_BITS) begin : g_addr_hi
    assign addr_hi_zero = (reg_addr_i[AW-1:SSL_ADDR_BITS] == '0);
  end else begin : g_addr_exact
    assign addr_hi_zero = 1'b1;
  end

  // Write strobes per register except the clock rise flag, read strobe for the sample register only
  assign wr_data_line  = reg_wr_i && addr_hi_zero && (addr == SSL_ADDR_DATA_LINE);
  assign wr_clock_line = reg_wr_i && addr_hi_zero && (addr == SSL_ADDR_CLOCK_LINE);
  assign wr_control    = reg_wr_i && addr_hi_zero && (addr == SSL_ADDR_CONTROL);
  assign wr_cond_one   = reg_wr_i && addr_hi_zero && (addr == SSL_ADDR_COND_ONE);
  assign wr_cond_two   = reg_wr_i && addr_hi_zero && (addr == SSL_ADDR_COND_TWO);
  assign wr_sample     = reg_wr_i && addr_hi_zero && (addr == SSL_ADDR_SAMPLE);
  assign rd_sample     = reg_rd_i && addr_hi_zero && (addr == SSL_ADDR_SAMPLE);

  // Edges of the synchronised lines, one cycle each
  assign clk_rise = line_s.clk && !line_prev_q.clk;
  assign clk_fall = !line_s.clk && line_prev_q.clk;
  assign dat_rise = line_s.dat && !line_prev_q.dat;
  assign dat_fall = !line_s.dat && line_prev_q.dat;

  // Conditions: clock high across a data edge, enabled only
  assign cond_one_hit = enable_q && dat_fall && line_s.clk && line_prev_q.clk;
  assign cond_two_hit = enable_q && dat_rise && line_s.clk && line_prev_q.clk;

  // Stretch request at a clock falling edge
  assign stretch_set = enable_q && clk_fall &&
                       (str_always_q || (str_cond_q && cond_one_q));

  // Open-drain pull-down requests from the block
  assign clk_pull_low = !clock_out_q || stretch_q;
  assign dat_pull_low = !data_out_q;

  // Previous synchronised levels for edge detection
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      line_prev_q <= '{clk: SSL_RST_LINE_IDLE, dat: SSL_RST_LINE_IDLE};
    end else begin
      line_prev_q <= line_s;
    end
  end

  // Data line drive bit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      data_out_q <= SSL_RST_DATA_OUT;
    end else if (wr_data_line) begin
      data_out_q <= reg_wdata_i[SSL_LINE_BIT];
    end
  end

  // Clock line drive bit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      clock_out_q <= SSL_RST_CLOCK_OUT;
    end else if (wr_clock_line) begin
      clock_out_q <= reg_wdata_i[SSL_LINE_BIT];
    end
  end

  // Control bits written by software
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      enable_q     <= SSL_RST_ENABLE;
      str_always_q <= SSL_RST_STR_ALWAYS;
      str_cond_q   <= SSL_RST_STR_COND;
    end else if (wr_control) begin
      enable_q     <= reg_wdata_i[SSL_CTRL_ENABLE];
      str_always_q <= reg_wdata_i[SSL_CTRL_STR_ALWAYS];
      str_cond_q   <= reg_wdata_i[SSL_CTRL_STR_COND];
    end
  end

  // Stretch flag: set beats release, dropped when disabled
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      stretch_q <= SSL_RST_FLAG;
    end else if (!enable_q) begin
      stretch_q <= 1'b0;
    end else if (stretch_set) begin
      stretch_q <= 1'b1;
    end else if (wr_sample) begin
      stretch_q <= 1'b0;
    end
  end

  // Condition one flag, detection wins over clear
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cond_one_q <= SSL_RST_FLAG;
    end else if (cond_one_hit) begin
      cond_one_q <= 1'b1;
    end else if (wr_cond_one) begin
      cond_one_q <= 1'b0;
    end
  end

  // Condition two flag, detection wins over clear
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cond_two_q <= SSL_RST_FLAG;
    end else if (cond_two_hit) begin
      cond_two_q <= 1'b1;
    end else if (wr_cond_two) begin
      cond_two_q <= 1'b0;
    end
  end

  // Data level captured at each clock rising edge while enabled
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sample_q <= SSL_RST_SAMPLE;
    end else if (enable_q && clk_rise) begin
      sample_q <= line_s.dat;
    end
  end

  // Clock rise flag, new edge wins over a read
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      clk_rise_q <= SSL_RST_FLAG;
    end else if (enable_q && clk_rise) begin
      clk_rise_q <= 1'b1;
    end else if (rd_sample) begin
      clk_rise_q <= 1'b0;
    end
  end

  // Condition one request pulse, one cycle per detection
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_one_q <= SSL_RST_FLAG;
    end else begin
      irq_one_q <= cond_one_hit;
    end
  end

  // Condition two request pulse, one cycle per detection
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_two_q <= SSL_RST_FLAG;
    end else begin
      irq_two_q <= cond_two_hit;
    end
  end

  // Pad output value: low while enabled, so the enable alone pulls down
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pad_out_q <= '0;
    end else if (enable_q) begin
      pad_out_q <= '0;
    end else begin
      pad_out_q <= portb_out_i;
    end
  end

  // Pad output enable: block owns both pins while enabled, else port B
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pad_oe_q <= '0;
    end else if (enable_q) begin
      pad_oe_q <= '{clk: clk_pull_low, dat: dat_pull_low};
    end else begin
      pad_oe_q <= portb_oe_i;
    end
  end

  // Read data selection; unused bits and addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (addr_hi_zero) begin
      case (addr)
        SSL_ADDR_DATA_LINE:  rdata_d[SSL_LINE_BIT] = line_s.dat;
        SSL_ADDR_CLOCK_LINE: rdata_d[SSL_LINE_BIT] = line_s.clk;
        SSL_ADDR_CONTROL: begin
          rdata_d[SSL_CTRL_ENABLE]     = enable_q;
          rdata_d[SSL_CTRL_STR_ALWAYS] = str_always_q;
          rdata_d[SSL_CTRL_STR_COND]   = str_cond_q;
          rdata_d[SSL_CTRL_STR_ACTIVE] = stretch_q;
        end
        SSL_ADDR_COND_ONE:   rdata_d[SSL_FLAG_BIT] = cond_one_q;
        SSL_ADDR_COND_TWO:   rdata_d[SSL_FLAG_BIT] = cond_two_q;
        SSL_ADDR_SAMPLE:     rdata_d[SSL_LINE_BIT] = sample_q;
        SSL_ADDR_CLK_RISE:   rdata_d[SSL_FLAG_BIT] = clk_rise_q;
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  // Read data register, loaded on a read strobe, cleared to zero otherwise
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_q <= SSL_RST_RDATA;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Synchronised levels returned to port B
  ssl_lines_t portb_in_q;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      portb_in_q <= '{clk: SSL_RST_LINE_IDLE, dat: SSL_RST_LINE_IDLE};
    end else begin
      portb_in_q <= line_s;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_o    = rdata_q;
  assign pad_out_o      = pad_out_q;
  assign pad_oe_o       = pad_oe_q;
  assign portb_in_o     = portb_in_q;
  assign cond_one_irq_o = irq_one_q;
  assign cond_two_irq_o = irq_two_q;

endmodule // ssl_core

// file: common/ssl_pkg.sv
// Purpose: Shared constants and types for the serial line assist block.
// Assumes: 8-bit register data, registers one per address word.
// Notes:   Index values below double as the plain-port register addresses.
package ssl_pkg;

  // Register addresses on the plain register port
  localparam logic [2:0] SSL_ADDR_DATA_LINE  = 3'h0;
  localparam logic [2:0] SSL_ADDR_CLOCK_LINE = 3'h1;
  localparam logic [2:0] SSL_ADDR_CONTROL    = 3'h2;
  localparam logic [2:0] SSL_ADDR_COND_ONE   = 3'h3;
  localparam logic [2:0] SSL_ADDR_COND_TWO   = 3'h4;
  localparam logic [2:0] SSL_ADDR_SAMPLE     = 3'h5;
  localparam logic [2:0] SSL_ADDR_CLK_RISE   = 3'h6;
  localparam int         SSL_ADDR_BITS       = 3;

  // Field positions
  localparam int SSL_LINE_BIT        = 0;
  localparam int SSL_CTRL_ENABLE     = 0;
  localparam int SSL_CTRL_STR_ALWAYS = 1;
  localparam int SSL_CTRL_STR_COND   = 2;
  localparam int SSL_CTRL_STR_ACTIVE = 3;
  localparam int SSL_FLAG_BIT        = 0;

  // Values after reset
  localparam logic       SSL_RST_DATA_OUT   = 1'b1;
  localparam logic       SSL_RST_CLOCK_OUT  = 1'b1;
  localparam logic       SSL_RST_ENABLE     = 1'b0;
  localparam logic       SSL_RST_STR_ALWAYS = 1'b0;
  localparam logic       SSL_RST_STR_COND   = 1'b0;
  localparam logic       SSL_RST_FLAG       = 1'b0;
  localparam logic       SSL_RST_SAMPLE     = 1'b0;
  localparam logic       SSL_RST_LINE_IDLE  = 1'b1;
  localparam logic [7:0] SSL_RST_RDATA      = 8'h00;

  // Synchroniser depth on pin inputs
  localparam int SSL_SYNC_STAGES = 2;

  // The two serial lines: clock on port B bit four, data on port B bit five
  typedef struct packed {
    logic clk;
    logic dat;
  } ssl_lines_t;

endpackage

// file: core/ssl_sync.sv
// Purpose: Multi-stage synchroniser for pin levels entering the system clock.
// Assumes: Inputs are quasi-static against the sampling clock; reset is sync.
// Notes:   Only the last stage leaves the module; earlier stages feed nothing else.
`timescale 1ns/1ps
module ssl_sync
  import ssl_pkg::*;
#(
  parameter int         WIDTH  = 2,
  parameter int         STAGES = SSL_SYNC_STAGES,
  parameter logic [1:0] RST_V  = 2'h3
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // Refuse shapes the chain cannot serve
  if (STAGES < 2) begin : g_chk_stages
    $error("ssl_sync needs at least two stages");
  end
  if (WIDTH != 2) begin : g_chk_width
    $error("ssl_sync reset value is sized for two lines");
  end

  // One flop chain per line, each chain owned by its own process
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    logic [STAGES-1:0] chain_q;
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        chain_q <= {STAGES{RST_V[b]}};
      end else begin
        chain_q <= {chain_q[STAGES-2:0], async_i[b]};
      end
    end
    assign sync_o[b] = chain_q[STAGES-1]; // Last stage only
  end

endmodule // ssl_sync

// file: tb/ssl_core_properties.sv
// Purpose: Port-level properties of the serial line assist block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Sequences allow the one idle cycle the bench leaves between strobes.
`timescale 1ns/1ps
module ssl_core_chk
  import ssl_pkg::*;
#(
  parameter int AW = SSL_ADDR_BITS
) (
  input wire logic          mclk_i,
  input wire logic          rst_n_i,
  input wire logic [AW-1:0] reg_addr_i,
  input wire logic [7:0]    reg_wdata_i,
  input wire logic          reg_wr_i,
  input wire logic          reg_rd_i,
  input wire logic [7:0]    reg_rdata_o,
  input wire ssl_lines_t    pad_in_i,
  input wire ssl_lines_t    pad_out_o,
  input wire ssl_lines_t    pad_oe_o,
  input wire ssl_lines_t    portb_out_i,
  input wire ssl_lines_t    portb_oe_i,
  input wire ssl_lines_t    portb_in_o,
  input wire logic          cond_one_irq_o,
  input wire logic          cond_two_irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Read data upper bits
  chk_unused_bits_zero: assert property (
    reg_rd_i |=> reg_rdata_o[7:4] == 4'h0
      && ($past(reg_addr_i) == SSL_ADDR_CONTROL || reg_rdata_o[3:1] == 3'h0))
    else $error("unused read bits not zero");
  // Condition one interrupt request is a single pulse
  chk_irq_one_pulse: assert property (
    cond_one_irq_o |=> !cond_one_irq_o) else $error("condition one request too long");
  // Detections need the clock line high
  chk_cond_one_cause: assert property (
    cond_one_irq_o |-> portb_in_o.clk && !portb_in_o.dat) else $error("bad condition one");
  chk_cond_two_cause: assert property (
    cond_two_irq_o |-> portb_in_o.clk && portb_in_o.dat) else $error("bad condition two");
  // Control bits read back as written
  chk_ctrl_readback: assert property (
    (reg_wr_i && reg_addr_i == SSL_ADDR_CONTROL) ##2 (reg_rd_i && reg_addr_i == SSL_ADDR_CONTROL)
      |=> (reg_rdata_o & 8'h07) == ($past(reg_wdata_i, 3) & 8'h07))
    else $error("control read back differs");
  // Sample write drops the stretch flag
  chk_stretch_release: assert property (
    (reg_wr_i && reg_addr_i == SSL_ADDR_SAMPLE) ##2 (reg_rd_i && reg_addr_i == SSL_ADDR_CONTROL)
      |=> !reg_rdata_o[3]) else $error("stretch flag kept after sample write");
  // Write clears condition one flag
  chk_cond_clear: assert property (
    (reg_wr_i && reg_addr_i == SSL_ADDR_COND_ONE) ##2 (reg_rd_i && reg_addr_i == SSL_ADDR_COND_ONE)
      |=> !reg_rdata_o[0]) else $error("condition one flag kept after write");
  // Sample read clears the rise flag
  chk_rise_clear: assert property (
    (reg_rd_i && reg_addr_i == SSL_ADDR_SAMPLE) ##2 (reg_rd_i && reg_addr_i == SSL_ADDR_CLK_RISE)
      |=> !reg_rdata_o[0]) else $error("rise flag kept after sample read");
  // Port B drive reaches pads while the pad output value is nonzero (block off)
  chk_pad_follow: assert property (
    pad_out_o != 2'b00 |-> pad_out_o == $past(portb_out_i) && pad_oe_o == $past(portb_oe_i))
    else $error("pads do not follow port B");
endmodule // ssl_core_chk

bind ssl_core ssl_core_chk #(.AW(AW)) i_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pad_in_i(pad_in_i),
  .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .portb_out_i(portb_out_i),
  .portb_oe_i(portb_oe_i), .portb_in_o(portb_in_o), .cond_one_irq_o(cond_one_irq_o),
  .cond_two_irq_o(cond_two_irq_o)
);

// file: tb/ssl_peer.sv
// Purpose: Far-side serial device on the two open-drain lines.
// Assumes: Pull-ups on both lines; this model only ever pulls low.
// Notes:   Each step holds half a link period of 160 ns.
`timescale 1ns/1ps
module ssl_peer (
  input  wire logic mclk_i,
  input  wire logic clk_line_i,
  output logic      clk_pull_o,
  output logic      dat_pull_o
);
  // Both lines released at start
  initial begin
    clk_pull_o = 1'b0;
    dat_pull_o = 1'b0;
  end
  // One link step: release for 1, pull for 0
  task automatic drive(input logic c, input logic d);
    @(posedge mclk_i);
    clk_pull_o <= !c;
    dat_pull_o <= !d;
    repeat (3) @(posedge mclk_i);
  endtask
  // Wait, bounded, for a held clock line to come back high
  task automatic wait_high(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      @(posedge mclk_i);
      ok = clk_line_i;
    end
  endtask
endmodule // ssl_peer

// file: tb/ssl_core_bench.sv
// Purpose: Self-checking bench for the serial line assist block.
// Assumes: Pull-ups on both lines; peer model pulls low only.
// Notes:   Register accesses leave one idle cycle between strobes.
`timescale 1ns/1ps
module ssl_core_bench
  import ssl_pkg::*;
;
  logic       mclk_i, rst_n_i, reg_wr_i, reg_rd_i, clk_pull, dat_pull, ok, b, prev;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, q;
  logic [7:0] rst_exp [8] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  ssl_lines_t pad_lines, pad_out_o, pad_oe_o, portb_out_i, portb_oe_i, portb_in_o;
  logic       cond_one_irq_o, cond_two_irq_o;
  int         miscompares, num_checks;
  int         irq_one_n = 0;
  int         irq_two_n = 0;

  // Open-drain wires: any pull low wins
  assign pad_lines.clk = clk_pull ? 1'b0 : (pad_oe_o.clk ? pad_out_o.clk : 1'b1);
  assign pad_lines.dat = dat_pull ? 1'b0 : (pad_oe_o.dat ? pad_out_o.dat : 1'b1);

  ssl_core #(.AW(SSL_ADDR_BITS)) i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pad_in_i(pad_lines),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .portb_out_i(portb_out_i),
    .portb_oe_i(portb_oe_i), .portb_in_o(portb_in_o), .cond_one_irq_o(cond_one_irq_o),
    .cond_two_irq_o(cond_two_irq_o));
  ssl_peer i_peer (.mclk_i(mclk_i), .clk_line_i(pad_lines.clk), .clk_pull_o(clk_pull),
    .dat_pull_o(dat_pull));

  // 50 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // Interrupt request tallies
  always @(posedge mclk_i) begin
    if (cond_one_irq_o === 1'b1) irq_one_n <= irq_one_n + 1;
    if (cond_two_irq_o === 1'b1) irq_two_n <= irq_two_n + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // One register access; read data captured in the cycle after
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i    <= w;
    reg_rd_i    <= !w;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 q = reg_rdata_o;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    check(q, exp);
  endtask
  task automatic settle;
    repeat (6) @(posedge mclk_i);
    #1;
  endtask
  task automatic final_report;
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Peer waits for a held clock; a timeout ends the run
  task automatic release_wait;
    i_peer.wait_high(ok);
    check({7'h00, ok}, 8'h01);
    if (ok !== 1'b1) final_report();
    settle();
  endtask

  initial begin
    rst_n_i     = 1'b0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 3'h0;
    reg_wdata_i = 8'h00;
    portb_out_i = 2'b11;
    portb_oe_i  = 2'b00;
    miscompares = 0;
    num_checks  = 0;
    prev        = 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // Reset values, unmapped place included
    for (int a = 0; a < 8; a++) begin
      if (a != 5) rd_chk(3'(a), rst_exp[a]);
    end
    // Port B owns the pins until the block is enabled
    @(posedge mclk_i);
    portb_out_i <= 2'b00;
    portb_oe_i  <= 2'b11;
    settle();
    check({6'h00, pad_oe_o}, 8'h03);
    rd_chk(SSL_ADDR_DATA_LINE, 8'h00);
    acc(1'b1, SSL_ADDR_CONTROL, 8'hF1);
    rd_chk(SSL_ADDR_CONTROL, 8'h01);
    settle();
    check({6'h00, pad_oe_o}, 8'h00);
    check({6'h00, pad_out_o}, 8'h00);
    rd_chk(SSL_ADDR_CLOCK_LINE, 8'h01);
    @(posedge mclk_i);
    portb_out_i <= 2'b11;
    portb_oe_i  <= 2'b00;
    // Software data low then high under a high clock
    acc(1'b1, SSL_ADDR_DATA_LINE, 8'h00);
    settle();
    check({6'h00, pad_oe_o}, 8'h01);
    rd_chk(SSL_ADDR_DATA_LINE, 8'h00);
    acc(1'b1, SSL_ADDR_DATA_LINE, 8'hFF);
    settle();
    rd_chk(SSL_ADDR_DATA_LINE, 8'h01);
    rd_chk(SSL_ADDR_COND_ONE, 8'h01);
    rd_chk(SSL_ADDR_COND_TWO, 8'h01);
    acc(1'b1, SSL_ADDR_COND_ONE, 8'hA5);
    rd_chk(SSL_ADDR_COND_ONE, 8'h00);
    acc(1'b1, SSL_ADDR_COND_TWO, 8'h5A);
    rd_chk(SSL_ADDR_COND_TWO, 8'h00);
    // Software clock drive, then peer holds data low under a driven 1
    acc(1'b1, SSL_ADDR_CLOCK_LINE, 8'h00);
    settle();
    rd_chk(SSL_ADDR_CLOCK_LINE, 8'h00);
    acc(1'b1, SSL_ADDR_CLOCK_LINE, 8'h01);
    settle();
    i_peer.drive(1'b1, 1'b0);
    rd_chk(SSL_ADDR_DATA_LINE, 8'h00);
    check({6'h00, portb_in_o}, 8'h02);
    // Peer clocks in bits 1 and 0, then a stop
    for (int i = 0; i < 2; i++) begin
      b = (i == 0);
      i_peer.drive(1'b0, prev);
      i_peer.drive(1'b0, b);
      i_peer.drive(1'b1, b);
      rd_chk(SSL_ADDR_CLK_RISE, 8'h01);
      rd_chk(SSL_ADDR_SAMPLE, {7'h00, b});
      rd_chk(SSL_ADDR_CLK_RISE, 8'h00);
      prev = b;
    end
    i_peer.drive(1'b1, 1'b1);
    rd_chk(SSL_ADDR_COND_TWO, 8'h01);
    // Unconditional stretch until the sample place is written
    acc(1'b1, SSL_ADDR_CONTROL, 8'h03);
    i_peer.drive(1'b0, 1'b1);
    i_peer.drive(1'b1, 1'b1);
    rd_chk(SSL_ADDR_CONTROL, 8'h0B);
    rd_chk(SSL_ADDR_CLOCK_LINE, 8'h00);
    acc(1'b1, SSL_ADDR_SAMPLE, 8'h00);
    rd_chk(SSL_ADDR_CONTROL, 8'h03);
    release_wait();
    // Conditional stretch: no hold before condition one, hold after it
    acc(1'b1, SSL_ADDR_COND_ONE, 8'h00);
    acc(1'b1, SSL_ADDR_CONTROL, 8'h05);
    i_peer.drive(1'b0, 1'b1);
    i_peer.drive(1'b1, 1'b1);
    release_wait();
    rd_chk(SSL_ADDR_CONTROL, 8'h05);
    i_peer.drive(1'b1, 1'b0);
    i_peer.drive(1'b0, 1'b0);
    i_peer.drive(1'b1, 1'b0);
    rd_chk(SSL_ADDR_CONTROL, 8'h0D);
    acc(1'b1, SSL_ADDR_SAMPLE, 8'hFF);
    release_wait();
    i_peer.drive(1'b1, 1'b1);
    // Disabled block ignores line conditions
    acc(1'b1, SSL_ADDR_COND_ONE, 8'h00);
    acc(1'b1, SSL_ADDR_COND_TWO, 8'h00);
    acc(1'b1, SSL_ADDR_CONTROL, 8'h00);
    i_peer.drive(1'b1, 1'b0);
    i_peer.drive(1'b1, 1'b1);
    rd_chk(SSL_ADDR_COND_ONE, 8'h00);
    rd_chk(SSL_ADDR_COND_TWO, 8'h00);
    check(8'(irq_one_n), 8'h03);
    check(8'(irq_two_n), 8'h03);
    final_report();
  end
endmodule // ssl_core_bench
